// *** rtl/psc_defines.svh ***
// Offsets, field positions, reset values and decode tags of the power save control.
// Assumes a 13-bit Avalon byte address and 32-bit words.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PSC_OFF_PANEL_CFG 13'h0000
`define PSC_OFF_POWER     13'h0014
`define PSC_OFF_INT_STS   13'h0018
`define PSC_OFF_INT_MASK  13'h001c
`define PSC_OFF_GPIO_FUNC 13'h0020
`define PSC_OFF_GPIO_DIR  13'h0024
`define PSC_OFF_GPIO_OUT  13'h0028
`define PSC_OFF_GPIO_IN   13'h002c
`define PSC_OFF_USB       13'h0040

// ----------------------------------------------------------------
// Memory windows: lookup table 0x0800-0x083f, buffer 0x1000-0x13ff
// ----------------------------------------------------------------
`define PSC_LUT_TAG 7'h20
`define PSC_BUF_TAG 3'h4

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PSC_PS_EN_BIT     4
`define PSC_MC_PD_BIT     6
`define PSC_EVT_N         4
`define PSC_EVT_ENTER     0
`define PSC_EVT_LEAVE     1
`define PSC_EVT_RD_REFUSE 2
`define PSC_EVT_USB_REFUSE 3
`define PSC_PWM_DIV_RST   8'h04

`endif

// *** rtl/psc_pkg.sv ***
// Types shared by the power save control files.
// Assumes psc_defines.svh is on the include path.
package psc_pkg;
  typedef logic [12:0] psc_addr_t;
  typedef logic [31:0] psc_word_t;
  typedef logic [3:0]  psc_be_t;

  // Bus slave states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACCESS = 3'b010,
    ST_DONE   = 3'b100
  } psc_bus_state_t;
endpackage

// *** rtl/psc_mem.sv ***
// Single port word memory with byte enables and registered read data.
// Assumes one access per cycle; read data valid the cycle after en.
module psc_mem #(
  parameter int AW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          en_in,
  input  wire logic          we_in,
  input  wire logic [3:0]    be_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [31:0]   wdata_in,
  output logic      [31:0]   rdata_out
);
  // One storage array per byte lane, so no array is written from two processes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane_r [2**AW];

    // Read register only moves on an enabled read, so it holds otherwise
    always_ff @(posedge clk_in) begin
      if (en_in && we_in && be_in[b]) begin
        lane_r[addr_in] <= wdata_in[8*b +: 8];
      end
      if (en_in && !we_in) begin
        rdata_out[8*b +: 8] <= lane_r[addr_in];
      end
    end
  end
endmodule

// *** rtl/psc_power_save.sv ***
// Power save control with register slave, display buffer, lookup table and panel drive.
// Assumes an Avalon-MM master on SYS_CLK_IN and asynchronous GPIO pin inputs.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`include "psc_defines.svh"

module psc_power_save #(
  parameter int GPIO_W  = 8,
  parameter int PANEL_W = 16,
  parameter int BUF_AW  = 8,
  parameter int LUT_AW  = 4
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_IN,
  input  wire psc_pkg::psc_addr_t AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire psc_pkg::psc_word_t AVS_WRITEDATA_IN,
  input  wire psc_pkg::psc_be_t  AVS_BYTEENABLE_IN,
  output psc_pkg::psc_word_t     AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  output logic                   IRQ_OUT,
  output logic [PANEL_W-1:0]     PANEL_INTERFACE_OUTPUTS_OUT,
  output logic                   PANEL_LINE_OUT,
  output logic                   PULSE_WIDTH_CLOCK_OUT,
  output logic                   USB_RUN_OUT,
  input  wire logic [GPIO_W-1:0] GPIO_IN,
  output logic [GPIO_W-1:0]      GPIO_OUT,
  output logic [GPIO_W-1:0]      GPIO_OE_OUT
);
  import psc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  psc_bus_state_t      st_r, st_nxt;
  logic                ps_r, ps_prev_r, mem_pd_r;
  logic [7:0]          pwm_div_r, pwm_cnt_r;
  logic [`PSC_EVT_N-1:0] sts_r, sts_nxt, mask_r, evt;
  logic [GPIO_W-1:0]   gpio_func_r, gpio_dir_r, gpio_out_r, gpio_in_r;
  logic [GPIO_W-1:0]   gsync1_r, gsync2_r, gsync3_r;
  psc_word_t           usb_r, hold_r, reg_rdata, buf_rdata, lut_rdata;
  logic                buf_rd_pend_r, lut_rd_pend_r, refresh_vld_r;
  logic [BUF_AW-1:0]   refresh_addr_r;

  function automatic psc_word_t wmask(psc_word_t old, psc_word_t wd, psc_be_t be);
    psc_word_t res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Everything is decoded from the live bus while the slave is idle
  wire take       = (st_r == ST_IDLE) && (AVS_READ_IN || AVS_WRITE_IN);
  wire wr_take    = take && AVS_WRITE_IN;
  wire rd_take    = take && AVS_READ_IN;
  wire sel_buf    = AVS_ADDRESS_IN[12:10] == `PSC_BUF_TAG;
  wire sel_lut    = AVS_ADDRESS_IN[12:6] == `PSC_LUT_TAG;
  wire sel_usb    = AVS_ADDRESS_IN == `PSC_OFF_USB;
  wire we_cfg     = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_PANEL_CFG);
  wire we_power   = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_POWER);
  wire we_sts     = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_INT_STS);
  wire we_mask    = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_INT_MASK);
  wire we_gfunc   = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_GPIO_FUNC);
  wire we_gdir    = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_GPIO_DIR);
  wire we_gout    = wr_take && (AVS_ADDRESS_IN == `PSC_OFF_GPIO_OUT);
  wire we_usb     = wr_take && sel_usb && !ps_r;
  wire usb_refuse = take && sel_usb && ps_r;
  wire wd_ps      = AVS_WRITEDATA_IN[`PSC_PS_EN_BIT];

  // ----------------------------------------------------------------
  // Display buffer port sharing
  // ----------------------------------------------------------------
  // Writes always reach the buffer; the controller wakes just for them
  wire host_buf_wr  = wr_take && sel_buf;
  wire host_buf_rd  = rd_take && sel_buf && !ps_r;
  wire buf_refuse   = rd_take && sel_buf && ps_r;
  wire host_buf     = host_buf_wr || host_buf_rd;
  // Host has priority; refresh only fills idle cycles of normal mode
  wire refresh_go   = !ps_r && !(take && sel_buf);
  wire buf_en       = host_buf || refresh_go;
  wire [BUF_AW-1:0] buf_addr = host_buf ? AVS_ADDRESS_IN[BUF_AW+1:2] : refresh_addr_r;
  wire lut_en       = take && sel_lut;
  wire lut_we       = wr_take && sel_lut;

  psc_mem #(.AW(BUF_AW)) u_display_buffer (
    .clk_in    (SYS_CLK_IN),
    .en_in     (buf_en),
    .we_in     (host_buf_wr),
    .be_in     (AVS_BYTEENABLE_IN),
    .addr_in   (buf_addr),
    .wdata_in  (AVS_WRITEDATA_IN),
    .rdata_out (buf_rdata)
  );

  psc_mem #(.AW(LUT_AW)) u_colour_lookup_table (
    .clk_in    (SYS_CLK_IN),
    .en_in     (lut_en),
    .we_in     (lut_we),
    .be_in     (AVS_BYTEENABLE_IN),
    .addr_in   (AVS_ADDRESS_IN[LUT_AW+1:2]),
    .wdata_in  (AVS_WRITEDATA_IN),
    .rdata_out (lut_rdata)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  wire psc_word_t power_rd = (32'(ps_r) << `PSC_PS_EN_BIT) | (32'(mem_pd_r) << `PSC_MC_PD_BIT);
  assign reg_rdata =
    (AVS_ADDRESS_IN == `PSC_OFF_PANEL_CFG) ? 32'(pwm_div_r)   :
    (AVS_ADDRESS_IN == `PSC_OFF_POWER)     ? power_rd         :
    (AVS_ADDRESS_IN == `PSC_OFF_INT_STS)   ? 32'(sts_r)       :
    (AVS_ADDRESS_IN == `PSC_OFF_INT_MASK)  ? 32'(mask_r)      :
    (AVS_ADDRESS_IN == `PSC_OFF_GPIO_FUNC) ? 32'(gpio_func_r) :
    (AVS_ADDRESS_IN == `PSC_OFF_GPIO_DIR)  ? 32'(gpio_dir_r)  :
    (AVS_ADDRESS_IN == `PSC_OFF_GPIO_OUT)  ? 32'(gpio_out_r)  :
    (AVS_ADDRESS_IN == `PSC_OFF_GPIO_IN)   ? 32'(gpio_in_r)   :
    (sel_usb && !ps_r)                     ? usb_r            :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus slave sequencing
  // ----------------------------------------------------------------
  // Fixed three-state walk keeps the answer time constant for all targets
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:   st_nxt = take ? ST_ACCESS : ST_IDLE;
      ST_ACCESS: st_nxt = ST_DONE;
      ST_DONE:   st_nxt = ST_IDLE;
      default:   st_nxt = ST_IDLE;
    endcase
  end

  // State and waitrequest
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      st_r                <= ST_IDLE;
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      st_r                <= st_nxt;
      AVS_WAITREQUEST_OUT <= (st_nxt != ST_DONE);
    end
  end

  // Capture read source at take, data at answer
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      hold_r           <= 32'h0000_0000;
      buf_rd_pend_r    <= 1'b0;
      lut_rd_pend_r    <= 1'b0;
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (take) begin
      hold_r        <= reg_rdata;
      buf_rd_pend_r <= host_buf_rd;
      lut_rd_pend_r <= rd_take && sel_lut;
    end else if (st_r == ST_ACCESS) begin
      // Refused buffer reads answer zero from hold_r
      AVS_READDATA_OUT <= buf_rd_pend_r ? buf_rdata : lut_rd_pend_r ? lut_rdata : hold_r;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Byte-merged write values, sliced down below to each register's width
  wire psc_word_t mask_wd  = wmask(32'(mask_r), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
  wire psc_word_t gfunc_wd = wmask(32'(gpio_func_r), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
  wire psc_word_t gdir_wd  = wmask(32'(gpio_dir_r), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
  wire psc_word_t gout_wd  = wmask(32'(gpio_out_r), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);

  // No mode change touches these; only bus writes do
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      pwm_div_r   <= `PSC_PWM_DIV_RST;
      mask_r      <= '0;
      gpio_func_r <= '0;
      gpio_dir_r  <= '0;
      gpio_out_r  <= '0;
      usb_r       <= 32'h0000_0000;
    end else begin
      if (we_cfg && AVS_BYTEENABLE_IN[0]) pwm_div_r <= AVS_WRITEDATA_IN[7:0];
      if (we_mask) mask_r <= mask_wd[`PSC_EVT_N-1:0];
      if (we_gfunc) gpio_func_r <= gfunc_wd[GPIO_W-1:0];
      if (we_gdir) gpio_dir_r <= gdir_wd[GPIO_W-1:0];
      if (we_gout) gpio_out_r <= gout_wd[GPIO_W-1:0];
      if (we_usb) usb_r <= wmask(usb_r, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Reset lands in power save; only the enable bit moves the mode
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ps_r      <= 1'b1;
      ps_prev_r <= 1'b1;
      mem_pd_r  <= 1'b1;
      USB_RUN_OUT <= 1'b0;
    end else begin
      if (we_power && AVS_BYTEENABLE_IN[0]) ps_r <= wd_ps;
      ps_prev_r   <= ps_r;
      mem_pd_r    <= ps_r && !host_buf_wr;
      USB_RUN_OUT <= !ps_r;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and line
  // ----------------------------------------------------------------
  assign evt[`PSC_EVT_ENTER]      = ps_r && !ps_prev_r;
  assign evt[`PSC_EVT_LEAVE]      = !ps_r && ps_prev_r;
  assign evt[`PSC_EVT_RD_REFUSE]  = buf_refuse;
  assign evt[`PSC_EVT_USB_REFUSE] = usb_refuse;
  // Set beats a same-cycle write-one clear
  wire [`PSC_EVT_N-1:0] sts_clr = we_sts && AVS_BYTEENABLE_IN[0] ?
                                  AVS_WRITEDATA_IN[`PSC_EVT_N-1:0] : '0;
  assign sts_nxt = (sts_r & ~sts_clr) | evt;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sts_r   <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      sts_r   <= sts_nxt;
      IRQ_OUT <= |(sts_nxt & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Refresh and panel drive
  // ----------------------------------------------------------------
  // Refresh address only advances on real refresh reads
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      refresh_addr_r <= '0;
      refresh_vld_r  <= 1'b0;
    end else begin
      if (refresh_go) refresh_addr_r <= refresh_addr_r + 1'b1;
      refresh_vld_r <= refresh_go;
    end
  end

  wire line_wrap = refresh_go && (refresh_addr_r == '1);

  // Panel signals low while saving, refreshed pixels otherwise
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN || ps_r) begin
      PANEL_INTERFACE_OUTPUTS_OUT <= '0;
      PANEL_LINE_OUT              <= 1'b0;
    end else begin
      if (refresh_vld_r) PANEL_INTERFACE_OUTPUTS_OUT <= buf_rdata[PANEL_W-1:0];
      PANEL_LINE_OUT <= line_wrap;
    end
  end

  // Pulse clock: toggles every pwm_div_r+1 cycles, held low in power save
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN || ps_r) begin
      pwm_cnt_r             <= 8'h00;
      PULSE_WIDTH_CLOCK_OUT <= 1'b0;
    end else if (pwm_cnt_r >= pwm_div_r) begin
      pwm_cnt_r             <= 8'h00;
      PULSE_WIDTH_CLOCK_OUT <= !PULSE_WIDTH_CLOCK_OUT;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // General purpose pins
  // ----------------------------------------------------------------
  // Special pins carry the line pulse; plain pins keep working always
  for (genvar g = 0; g < GPIO_W; g++) begin : g_pin
    always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
        gsync1_r[g]    <= 1'b0;
        gsync2_r[g]    <= 1'b0;
        gsync3_r[g]    <= 1'b0;
        gpio_in_r[g]   <= 1'b0;
        GPIO_OUT[g]    <= 1'b0;
        GPIO_OE_OUT[g] <= 1'b0;
      end else begin
        gsync1_r[g] <= GPIO_IN[g];
        gsync2_r[g] <= gsync1_r[g];
        gsync3_r[g] <= gsync2_r[g];
        // Two later stages must agree, filtering a one-cycle glitch
        if (gsync2_r[g] == gsync3_r[g]) gpio_in_r[g] <= gsync3_r[g];
        GPIO_OUT[g]    <= gpio_func_r[g] ? (!ps_r && line_wrap) : gpio_out_r[g];
        GPIO_OE_OUT[g] <= gpio_func_r[g] || gpio_dir_r[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_power_follows_bit: assert property (we_power && AVS_BYTEENABLE_IN[0] |=>
    ps_r == $past(wd_ps)) else $error("mode ignores enable write");
  a_panel_held_low: assert property (ps_r |=>
    (PANEL_INTERFACE_OUTPUTS_OUT == '0) && !PANEL_LINE_OUT) else $error("panel driven");
  a_pulse_clock_stop: assert property (ps_r [*2] |=>
    !PULSE_WIDTH_CLOCK_OUT && pwm_cnt_r == 8'h00) else $error("pulse clock running");
  a_no_refresh_read: assert property (ps_r |->
    !refresh_go && !(buf_en && !host_buf)) else $error("refresh read in power save");
  a_memctl_status: assert property (ps_r && !host_buf_wr |=>
    mem_pd_r && power_rd[`PSC_MC_PD_BIT]) else $error("controller status not set");
  a_memctl_awake: assert property (!ps_r |=> !mem_pd_r)
    else $error("controller status set in normal mode");
  a_buf_write_kept: assert property (host_buf_wr |->
    buf_en && buf_addr == AVS_ADDRESS_IN[BUF_AW+1:2]) else $error("buffer write dropped");
  a_buf_read_refused: assert property (buf_refuse |-> !buf_en ##2
    (AVS_READDATA_OUT == 32'h0000_0000) && !AVS_WAITREQUEST_OUT) else $error("refused read");
  a_lut_open: assert property (take && sel_lut |-> lut_en ##2 !AVS_WAITREQUEST_OUT)
    else $error("lookup table access blocked");
  a_usb_stopped: assert property (ps_r |=> !USB_RUN_OUT)
    else $error("usb running in power save");
  a_usb_reg_frozen: assert property (usb_refuse |=>
    $stable(usb_r) && sts_r[`PSC_EVT_USB_REFUSE]) else $error("usb register served");
  a_special_pin_low: assert property (ps_r |=>
    (GPIO_OUT & $past(gpio_func_r)) == '0) else $error("special pin active in power save");
  a_plain_pin_out: assert property (1'b1 |=> (GPIO_OUT & ~$past(gpio_func_r)) ==
    ($past(gpio_out_r) & ~$past(gpio_func_r))) else $error("plain pin does not follow");
  a_reset_in_save: assert property ($past(RST_IN) |->
    ps_r && power_rd[`PSC_PS_EN_BIT]) else $error("not in power save after reset");
  a_config_kept: assert property ($changed(ps_r) |->
    $stable(pwm_div_r) && $stable(gpio_func_r) && $stable(mask_r)) else $error("config altered");
  a_answer_time: assert property (take |-> AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT
    ##1 !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT) else $error("answer timing wrong");

  // A full line of refresh may pass before the first line pulse
  c_leave_save: cover property (ps_r ##1 !ps_r ##[1:600] PANEL_LINE_OUT);
  c_usb_refused: cover property (usb_refuse ##2 !AVS_WAITREQUEST_OUT);
  c_write_in_save: cover property (ps_r && host_buf_wr);
  c_refused_read: cover property (buf_refuse ##2 !AVS_WAITREQUEST_OUT);
  c_irq_raise: cover property (!IRQ_OUT ##1 IRQ_OUT);
endmodule

// *** verification/psc_host_model.sv ***
// Host model: Avalon-MM master, one word access at a time.
// Assumes calls start just after a rising edge of clk_in.
`include "psc_defines.svh"
module psc_host_model (
  input  wire logic               clk_in,
  output psc_pkg::psc_addr_t      address_out = '0,
  output logic                    read_out = 1'b0,
  output logic                    write_out = 1'b0,
  output psc_pkg::psc_word_t      writedata_out = '0,
  output psc_pkg::psc_be_t        byteenable_out = 4'hf,
  input  wire psc_pkg::psc_word_t readdata_in,
  input  wire logic               waitrequest_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  psc_word_t last_q;
  // Request held until waitrequest low is sampled; data taken at that edge
  task automatic access(input logic wr, input psc_addr_t a, input psc_word_t d);
    @(posedge clk_in);
    address_out <= a;
    writedata_out <= d;
    write_out <= wr;
    read_out <= ~wr;
    @(posedge clk_in);
    while (waitrequest_in !== 1'b0) @(posedge clk_in);
    last_q = readdata_in;
    write_out <= 1'b0;
    read_out <= 1'b0;
  endtask
  task automatic wr(input psc_addr_t a, input psc_word_t d);
    access(1'b1, a, d);
  endtask
  task automatic rd(input psc_addr_t a, output psc_word_t q);
    access(1'b0, a, '0);
    q = last_q;
  endtask
  // Setup first, leaving power save last, so the pulse clock never runs unconfigured
  task automatic bring_up(input psc_word_t div);
    wr(`PSC_OFF_PANEL_CFG, div);
    wr(`PSC_OFF_POWER, 32'h0);
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench: power save control driven by the host model.
// Assumes rtl/ on the include path; 100 MHz clock, reset held 5 cycles.
`include "psc_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  gpio_in = 8'h00;
  psc_addr_t   address;
  psc_word_t   wdata, rdata;
  psc_be_t     be;
  logic        read, write, waitreq, irq, line, pwm, usb_run;
  logic [15:0] panel;
  logic [7:0]  gpio_out, gpio_oe;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0, line_cnt = 0, pin_cnt = 0;
  // Free running clock
  always #5 clk = ~clk;
  // Design with every input driven
  psc_power_save uut (.SYS_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(address),
    .AVS_READ_IN(read), .AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .IRQ_OUT(irq), .PANEL_INTERFACE_OUTPUTS_OUT(panel), .PANEL_LINE_OUT(line),
    .PULSE_WIDTH_CLOCK_OUT(pwm), .USB_RUN_OUT(usb_run), .GPIO_IN(gpio_in),
    .GPIO_OUT(gpio_out), .GPIO_OE_OUT(gpio_oe));
  // Host on the register bus
  psc_host_model host (.clk_in(clk), .address_out(address), .read_out(read),
    .write_out(write), .writedata_out(wdata), .byteenable_out(be),
    .readdata_in(rdata), .waitrequest_in(waitreq));
  // Pulse counters and hang limit, well above the few thousand cycles used
  always @(posedge clk) begin
    cycles++;
    if (line === 1'b1) line_cnt++;
    if (gpio_out[0] === 1'b1) pin_cnt++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Reset state, power save accesses, refusals and their interrupt
  task automatic t_save();
    psc_word_t q;
    `CHK({panel, line, pwm, usb_run, irq}, 20'h0)
    host.rd(`PSC_OFF_POWER, q);
    `CHK({q[6], q[4]}, 2'b11)
    host.wr(13'h804, 32'h12345678);
    host.rd(13'h804, q);
    `CHK(q, 32'h12345678)
    for (int i = 0; i < 256; i++)
      host.wr(13'h1000 + 13'(i * 4), {16'h0, 8'ha5, 8'(i)});
    host.rd(13'h1008, q);
    `CHK(q, 32'h0)
    host.wr(`PSC_OFF_USB, 32'hc3);
    host.rd(`PSC_OFF_USB, q);
    `CHK(q, 32'h0)
    host.rd(13'h100, q);
    `CHK(q, 32'h0)
    host.wr(`PSC_OFF_INT_MASK, 32'h4);
    @(posedge clk);
    `CHK(irq, 1'b1)
    host.wr(`PSC_OFF_INT_STS, 32'hf);
    host.wr(`PSC_OFF_INT_MASK, 32'h0);
    host.rd(`PSC_OFF_INT_STS, q);
    `CHK({irq, q[3:0], line_cnt == 0, panel}, {5'h0, 1'b1, 16'h0})
  endtask
  // Pins in power save: special pin low, plain pins live
  task automatic t_gpio();
    psc_word_t q;
    host.wr(`PSC_OFF_GPIO_FUNC, 32'h1);
    host.wr(`PSC_OFF_GPIO_DIR, 32'h2);
    host.wr(`PSC_OFF_GPIO_OUT, 32'h3);
    @(posedge clk);
    `CHK({gpio_oe[1:0], gpio_out[1:0]}, 4'he)
    gpio_in <= 8'h5a;
    repeat (6) @(posedge clk);
    host.rd(`PSC_OFF_GPIO_IN, q);
    `CHK(q[7:0], 8'h5a)
  endtask
  // Normal mode: clock period, refresh, USB and buffer reads
  task automatic t_leave();
    psc_word_t q;
    int n;
    logic p;
    host.bring_up(32'h2);
    host.rd(`PSC_OFF_POWER, q);
    `CHK({q[6], q[4], usb_run}, 3'b001)
    p = pwm;
    for (n = 0; n < 20 && pwm === p; n++) @(posedge clk);
    p = pwm;
    for (n = 0; n < 20 && pwm === p; n++) @(posedge clk);
    `CHK(n, 3)
    for (n = 0; n < 4000 && pin_cnt == 0; n++) @(posedge clk);
    `CHK({line_cnt > 0, pin_cnt > 0}, 2'b11)
    `CHK(panel[15:8], 8'ha5)
    host.wr(`PSC_OFF_USB, 32'hc3);
    host.rd(`PSC_OFF_USB, q);
    `CHK(q, 32'hc3)
    host.rd(13'h1008, q);
    `CHK(q, 32'ha502)
    host.rd(`PSC_OFF_INT_STS, q);
    `CHK(q[1], 1'b1)
  endtask
  // Back to power save: outputs drop, contents kept
  task automatic t_reenter();
    psc_word_t q;
    host.wr(`PSC_OFF_POWER, 32'h10);
    line_cnt = 0;
    @(posedge clk);
    `CHK({panel, pwm, usb_run}, 18'h0)
    repeat (600) @(posedge clk);
    `CHK(line_cnt, 0)
    host.rd(`PSC_OFF_POWER, q);
    `CHK({q[6], q[4]}, 2'b11)
    host.rd(`PSC_OFF_PANEL_CFG, q);
    `CHK(q[7:0], 8'h02)
    host.rd(13'h804, q);
    `CHK(q, 32'h12345678)
    host.rd(`PSC_OFF_INT_STS, q);
    `CHK(q[0], 1'b1)
  endtask
  // Reset in mid-run from normal mode lands back in power save with defaults
  task automatic t_reset();
    psc_word_t q;
    host.wr(`PSC_OFF_POWER, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK({usb_run, irq, panel}, 18'h0)
    host.rd(`PSC_OFF_POWER, q);
    `CHK({q[6], q[4]}, 2'b11)
    host.rd(`PSC_OFF_PANEL_CFG, q);
    `CHK(q[7:0], `PSC_PWM_DIV_RST)
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_save();
    t_gpio();
    t_leave();
    t_reenter();
    t_reset();
    close_out();
  end
endmodule
